// File: core/fth_ctrl.sv
// apb controlled programmer for a one-time fuse trimmed amplifier
`timescale 1ns/1ps
`default_nettype none
`include "fth_params.svh"
// Function
// - short pulse sends zero, long pulse sends one, gaps at least ten microseconds
// - word is start pattern, function, parameter, dummy 10, value, end pattern
// - fields sent start to end, each most significant bit first
// - exactly one value bit per program command
// - wait at least one millisecond after each program command
// - master fuse: parameter 11 value bit zero; then programming refused
// - blow parity fuse before master only when data parity sum is one
module fth_ctrl (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic serial_pulse_input,
	input wire logic filter_readback_pin
);
	import fth_pkg::*;
	// ----------------------------------------
	// register bus
	// ----------------------------------------
	wire wr_en = psel && penable && pwrite;
	wire rd_en = psel && penable && !pwrite;
	wire sel_cmd = paddr == `FTH_REG_CMD;
	wire sel_stat = paddr == `FTH_REG_STAT;
	wire sel_rdata = paddr == `FTH_REG_RDATA;
	wire sel_trim = paddr == `FTH_REG_TRIM;
	wire mapped = sel_cmd || sel_stat || sel_rdata || sel_trim;
	fth_state_t state;
	fth_state_t next_state;
	fth_cmd_t cmd;
	fth_trim_t trim;
	logic locked;
	logic refused;
	logic badcmd;
	logic [7:0] rdata;
	logic [37:0] word;
	logic [5:0] bits_left;
	logic [3:0] rd_cnt;
	logic [15:0] wait_cnt;
	logic tx_start;
	logic tx_bit;
	logic tx_busy;
	wire busy = state != FTH_IDLE;
	function automatic logic one_hot8(input logic [7:0] v);
		return v != 8'h00 && (v & (v - 8'h01)) == 8'h00;
	endfunction : one_hot8
	// the parity sum is offered to software so it can decide on the parity fuse
	wire data_parity_sum = ^trim;
	wire [31:0] stat_word = {26'h000_0000, data_parity_sum, 1'b0, badcmd, refused, locked, busy};
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			prdata <= sel_cmd ? {20'h0_0000, cmd} :
				sel_stat ? stat_word :
				sel_rdata ? {24'h00_0000, rdata} :
				sel_trim ? {14'h0000, trim} : 32'h0000_0000;
		end
	end
	// ----------------------------------------
	// command acceptance
	// ----------------------------------------
	wire go = wr_en && sel_cmd && !busy;
	fth_cmd_t new_cmd;
	assign new_cmd = pwdata[11:0];
	wire is_prog = new_cmd.func == `FTH_FN_PROG;
	// program needs one value bit; locked parts refuse further blowing
	wire bad_prog = is_prog && !one_hot8(new_cmd.value);
	wire lock_prog = is_prog && locked;
	wire is_master = is_prog && new_cmd.param == `FTH_PAR_OTHER
		&& new_cmd.value == `FTH_VAL_MASTER;
	wire launch = go && !bad_prog && !lock_prog;
	wire [37:0] new_word = {`FTH_START_PAT, new_cmd.func, new_cmd.param, `FTH_DUMMY,
		new_cmd.value, `FTH_END_PAT};
	wire tx_ok = !tx_busy && !tx_start;
	wire word_done = state == FTH_SEND && bits_left == 6'h00 && tx_ok;
	wire read_pulse_done = state == FTH_RGAP && tx_ok;
	always_comb begin
		next_state = state;
		case (state)
			FTH_IDLE: if (launch) next_state = FTH_SEND;
			FTH_SEND: begin
				if (word_done) begin
					case (cmd.func)
						`FTH_FN_PROG: next_state = FTH_BLOW;
						`FTH_FN_READ: next_state = FTH_READ;
						default: next_state = FTH_IDLE;
					endcase
				end
			end
			FTH_BLOW: if (wait_cnt == 16'h0000) next_state = FTH_IDLE;
			FTH_READ: if (tx_ok) next_state = FTH_RGAP;
			FTH_RGAP: begin
				if (read_pulse_done)
					next_state = rd_cnt == `FTH_READ_PULSES ? FTH_IDLE : FTH_READ;
			end
			default: next_state = FTH_IDLE;
		endcase
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) state <= FTH_IDLE;
		else state <= next_state;
	end
	// ----------------------------------------
	// serial word shifting, msb first
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			word <= 38'h00_0000_0000;
			bits_left <= 6'h00;
			tx_start <= 1'b0;
			tx_bit <= 1'b0;
		end else begin
			tx_start <= 1'b0;
			if (launch) begin
				word <= new_word;
				bits_left <= 6'(`FTH_WORD_BITS);
			end else if (state == FTH_SEND && bits_left != 6'h00 && tx_ok) begin
				tx_bit <= word[37];
				tx_start <= 1'b1;
				word <= {word[36:0], 1'b0};
				bits_left <= bits_left - 6'h01;
			end else if (state == FTH_READ && tx_ok) begin
				tx_bit <= 1'b0; // short pulse clocks readback out
				tx_start <= 1'b1;
			end
		end
	end
	fth_pulse_tx u_tx (
		.pclk(pclk),
		.presetn(presetn),
		.start(tx_start),
		.bit_val(tx_bit),
		.busy(tx_busy),
		.serial_pulse_input(serial_pulse_input)
	);
	// ----------------------------------------
	// blow wait and readback capture
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wait_cnt <= 16'h0000;
		end else if (word_done) begin
			wait_cnt <= 16'(`FTH_CYC_BLOW);
		end else if (wait_cnt != 16'h0000) begin
			wait_cnt <= wait_cnt - 16'h0001;
		end
	end
	// sample before each pulse: first sample is the msb presented at entry
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata <= 8'h00;
			rd_cnt <= 4'h0;
		end else if (word_done && cmd.func == `FTH_FN_READ) begin
			rd_cnt <= 4'h0;
			rdata <= 8'h00;
		end else if (state == FTH_READ && tx_ok) begin
			rdata <= {rdata[6:0], filter_readback_pin};
			rd_cnt <= rd_cnt + 4'h1;
		end
	end
	// ----------------------------------------
	// status and local fuse image
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmd <= 12'h000;
			locked <= 1'b0;
			refused <= 1'b0;
			badcmd <= 1'b0;
			trim <= 18'h0_0000;
		end else begin
			if (go) begin
				cmd <= new_cmd;
				refused <= lock_prog;
				badcmd <= bad_prog;
			end
			if (launch && is_master) locked <= 1'b1;
			if (launch && is_prog) begin
				// blown fuses read as one, so the image only gains ones
				case (new_cmd.param)
					2'h0: trim.second_gain_bits <= trim.second_gain_bits | new_cmd.value[2:0];
					2'h1: trim.first_gain_bits <= trim.first_gain_bits | new_cmd.value[6:0];
					2'h2: trim.offset_trim_bits <= trim.offset_trim_bits | new_cmd.value;
					default: trim <= trim;
				endcase
			end
		end
	end
endmodule : fth_ctrl
`default_nettype wire

// File: pkg/fth_params.svh
// constants for the fuse trim programmer controller
`ifndef FTH_PARAMS_SVH
`define FTH_PARAMS_SVH
`define FTH_CLK_MHZ 40
`define FTH_T_SHORT_NS 1000
`define FTH_T_LONG_US 60
`define FTH_T_GAP_US 20
`define FTH_T_BLOW_US 1000
`define FTH_CYC_SHORT ((`FTH_T_SHORT_NS * `FTH_CLK_MHZ + 999) / 1000)
`define FTH_CYC_LONG (`FTH_T_LONG_US * `FTH_CLK_MHZ)
`define FTH_CYC_GAP (`FTH_T_GAP_US * `FTH_CLK_MHZ)
`define FTH_CYC_BLOW (`FTH_T_BLOW_US * `FTH_CLK_MHZ)
`define FTH_WORD_BITS 38
`define FTH_START_PAT 12'h801
`define FTH_END_PAT 12'h7fe
`define FTH_DUMMY 2'h2
`define FTH_FN_SENSE 2'h0
`define FTH_FN_SIM 2'h1
`define FTH_FN_PROG 2'h2
`define FTH_FN_READ 2'h3
`define FTH_PAR_OTHER 2'h3
`define FTH_VAL_MASTER 8'h01
`define FTH_VAL_PARITY 8'h04
`define FTH_READ_PULSES 4'h8
`define FTH_REG_CMD 12'h000
`define FTH_REG_STAT 12'h004
`define FTH_REG_RDATA 12'h008
`define FTH_REG_TRIM 12'h00c
`define FTH_ST_BUSY 0
`define FTH_ST_LOCKED 1
`define FTH_ST_REFUSED 2
`define FTH_ST_BADCMD 3
`endif

// File: pkg/fth_pkg.sv
// types for the fuse trim programmer controller
package fth_pkg;
	typedef struct packed {
		logic [1:0] func;
		logic [1:0] param;
		logic [7:0] value;
	} fth_cmd_t;
	typedef struct packed {
		logic [2:0] second_gain_bits;
		logic [6:0] first_gain_bits;
		logic [7:0] offset_trim_bits;
	} fth_trim_t;
	typedef enum logic [2:0] {
		FTH_IDLE = 3'b000,
		FTH_SEND = 3'b001,
		FTH_BLOW = 3'b010,
		FTH_READ = 3'b011,
		FTH_RGAP = 3'b100
	} fth_state_t;
endpackage : fth_pkg

// File: core/fth_pulse_tx.sv
// pulse width coder driving the single-wire serial input
`timescale 1ns/1ps
`default_nettype none
`include "fth_params.svh"
module fth_pulse_tx (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic start,
	input wire logic bit_val,
	output logic busy,
	output logic serial_pulse_input
);
	import fth_pkg::*;
	// ----------------------------------------
	// high phase then low gap, one bit each
	// ----------------------------------------
	logic [15:0] cnt;
	logic high;
	wire [15:0] high_len = bit_val ? 16'(`FTH_CYC_LONG) : 16'(`FTH_CYC_SHORT);
	wire done_high = high && cnt == 16'h0000;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 16'h0000;
			high <= 1'b0;
			busy <= 1'b0;
		end else if (start && !busy) begin
			cnt <= high_len - 16'h0001;
			high <= 1'b1;
			busy <= 1'b1;
		end else if (done_high) begin
			high <= 1'b0;
			cnt <= 16'(`FTH_CYC_GAP) - 16'h0001;
		end else if (cnt != 16'h0000) begin
			cnt <= cnt - 16'h0001;
		end else begin
			busy <= 1'b0;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			serial_pulse_input <= 1'b0;
		end else begin
			serial_pulse_input <= (start && !busy) || (high && !done_high);
		end
	end
endmodule : fth_pulse_tx
`default_nettype wire

// File: verification/fth_ctrl_asserts.sv
// concurrent checks on the fuse trim programmer ports
`timescale 1ns/1ps
`default_nettype none
`include "fth_params.svh"
module fth_ctrl_chk (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic serial_pulse_input
);
	// ----------------------------------------
	// pulse timing and bus answers
	// ----------------------------------------
	localparam int T_SHORT = `FTH_CYC_SHORT;
	localparam int T_LONG = `FTH_CYC_LONG;
	localparam int T_GAP = `FTH_CYC_GAP;
	logic [11:0] hi_cnt;
	logic [15:0] lo_cnt;
	wire mapped = paddr inside {`FTH_REG_CMD, `FTH_REG_STAT, `FTH_REG_RDATA, `FTH_REG_TRIM};
	// low count saturates so the first pulse after reset passes the gap check
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hi_cnt <= 12'h000;
			lo_cnt <= 16'hffff;
		end else begin
			hi_cnt <= serial_pulse_input ? hi_cnt + 12'h001 : 12'h000;
			lo_cnt <= serial_pulse_input ? 16'h0000 : lo_cnt + {15'h0000, lo_cnt != 16'hffff};
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_access;
		psel && penable;
	endsequence
	sequence s_bad_access;
		s_access ##0 !mapped;
	endsequence
	a_ready_zero_wait: assert property (s_access |-> pready) else $error("pready low");
	a_err_unmapped: assert property (s_bad_access |-> pslverr) else $error("no slverr");
	a_ok_mapped: assert property (s_access ##0 mapped |-> !pslverr) else $error("bad slverr");
	a_prdata_held: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
		else $error("prdata moved");
	a_pulse_width: assert property ($fell(serial_pulse_input) |->
		hi_cnt == T_SHORT || hi_cnt == T_LONG) else $error("pulse width");
	a_gap_min: assert property ($rose(serial_pulse_input) |-> lo_cnt >= T_GAP)
		else $error("gap short");
	a_rise_hold: assert property ($rose(serial_pulse_input) |-> serial_pulse_input[*8])
		else $error("glitch high");
	a_fall_hold: assert property ($fell(serial_pulse_input) |-> !serial_pulse_input[*8])
		else $error("glitch low");
endmodule : fth_ctrl_chk
bind fth_ctrl fth_ctrl_chk fth_ctrl_chk_i (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .serial_pulse_input(serial_pulse_input));
`default_nettype wire

// File: verification/fth_dev_model.sv
// behavioural model of the fuse trimmed amplifier serial port
`timescale 1ns/1ps
`default_nettype none
`include "fth_params.svh"
module fth_dev_model (
	input wire logic serial_pulse_input,
	output logic filter_readback_pin,
	output logic fault
);
	// ----------------------------------------
	// pulse decoder and fuse array
	// ----------------------------------------
	logic [37:0] sr = '0;
	logic [7:0] fz [4] = '{default: 8'h00};
	logic [7:0] rsr = 8'h00;
	logic [3:0] rcnt;
	logic rd_mode = 1'b0;
	logic low_cur = 1'b0;
	logic b;
	realtime t_rise = 0.0, t_fall = -1.0e9, t_free = 0.0, w;
	wire dsum = ^{fz[0][2:0], fz[1][6:0], fz[2]};
	wire pcmp = dsum ^ fz[3][2];
	wire perr = fz[3][0] & pcmp; // high would tie the output low
	// outside read mode the pin is analog, so show the inverse rather than a held bit
	assign filter_readback_pin = rd_mode ? rsr[7] : ~rsr[7];
	initial fault = 1'b0;
	always @(posedge serial_pulse_input) begin
		t_rise = $realtime;
		if (t_rise - t_fall < 10000.0 || t_rise < t_free) fault = 1'b1;
	end
	always @(negedge serial_pulse_input) if (t_rise > 0.0) begin
		t_fall = $realtime;
		w = t_fall - t_rise;
		b = (w >= 50000.0);
		if (!b && (w < 50.0 || w > 10000.0)) fault = 1'b1;
		if (rd_mode) begin
			rcnt = rcnt + 4'h1;
			if (rcnt == 4'h8) rd_mode = 1'b0;
			else rsr = rsr << 1;
		end else begin
			sr = {sr[36:0], b};
			if (sr[37:26] == `FTH_START_PAT && sr[11:0] == `FTH_END_PAT && sr[21:20] == `FTH_DUMMY) begin
				case (sr[25:24])
					2'b10: if (!fz[3][0]) begin
						if ($countones(sr[19:12]) != 1) fault = 1'b1;
						fz[sr[23:22]] = fz[sr[23:22]] | sr[19:12];
						t_free = t_fall + 1.0e6;
					end
					2'b11: begin
						rsr = fz[sr[23:22]] & (sr[23:22] == 2'b00 ? 8'h07 : sr[23:22] == 2'b01 ? 8'h7f : 8'hff);
						rd_mode = 1'b1;
						rcnt = 4'h0;
					end
					2'b00: if (sr[23:22] == 2'b00) low_cur = sr[12];
					default: ;
				endcase
				sr = '0;
			end
		end
	end
endmodule : fth_dev_model
`default_nettype wire

// File: verification/testbench.sv
// self-checking bench for the fuse trim programmer controller
`timescale 1ns/1ps
`default_nettype none
`include "fth_params.svh"
module testbench;
	// ----------------------------------------
	// harness and bus tasks
	// ----------------------------------------
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ser, rb, fault, e;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	int n_mismatch = 0;
	int samples_checked = 0;
	int cyc = 0;
	fth_ctrl fth_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .serial_pulse_input(ser), .filter_readback_pin(rb));
	fth_dev_model fth_dev_model_i (.serial_pulse_input(ser), .filter_readback_pin(rb), .fault(fault));
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s exp %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wait_idle();
		q = 32'h0000_0001;
		while (q[0] !== 1'b0) apb(1'b0, `FTH_REG_STAT, 32'h0000_0000);
	endtask : wait_idle
	task automatic conclude();
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : conclude
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	// words are long and fixed: three full words, one blow wait and eight read pulses
	// need about 260k cycles, so the ceiling leaves some margin above that
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 330000) begin
			n_mismatch++;
			conclude();
		end
	end
	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, `FTH_REG_STAT, 32'h0000_0000);
		check("stat", q, 32'h0000_0000);
		check("pin", {31'h0000_0000, ser}, 32'h0000_0000);
		apb(1'b0, 12'h010, 32'h0000_0000);
		check("slverr", {31'h0000_0000, e}, 32'h0000_0001);
		apb(1'b1, `FTH_REG_CMD, 32'h0000_0805);
		apb(1'b0, `FTH_REG_STAT, 32'h0000_0000);
		check("badcmd", q & 32'h0000_000f, 32'h0000_0008);
		apb(1'b1, `FTH_REG_CMD, 32'h0000_0b01);
		wait_idle();
		check("locked", q & 32'h0000_0002, 32'h0000_0002);
		check("master", {24'h00_0000, fth_dev_model_i.fz[3]}, 32'h0000_0001);
		check("perr", {31'h0000_0000, fth_dev_model_i.perr}, 32'h0000_0000);
		apb(1'b1, `FTH_REG_CMD, 32'h0000_0804);
		apb(1'b0, `FTH_REG_STAT, 32'h0000_0000);
		check("refused", q & 32'h0000_0004, 32'h0000_0004);
		apb(1'b1, `FTH_REG_CMD, 32'h0000_0f00);
		wait_idle();
		apb(1'b0, `FTH_REG_RDATA, 32'h0000_0000);
		check("rdata", q, 32'h0000_0001);
		check("rdmode", {31'h0000_0000, fth_dev_model_i.rd_mode}, 32'h0000_0000);
		check("fault", {31'h0000_0000, fault}, 32'h0000_0000);
		check("gain", {24'h00_0000, fth_dev_model_i.fz[0]}, 32'h0000_0000);
		// sense current command: only the word is sent, no blow wait and no readback
		apb(1'b1, `FTH_REG_CMD, 32'h0000_0001);
		wait_idle();
		check("stat2", q, 32'h0000_0002);
		check("lowcur", {31'h0000_0000, fth_dev_model_i.low_cur}, 32'h0000_0001);
		apb(1'b0, `FTH_REG_CMD, 32'h0000_0000);
		check("cmd", q, 32'h0000_0001);
		apb(1'b0, `FTH_REG_TRIM, 32'h0000_0000);
		check("trim", q, 32'h0000_0000);
		check("fault2", {31'h0000_0000, fault}, 32'h0000_0000);
		conclude();
	end
endmodule : testbench
`default_nettype wire
